// file: verilog/pse_map.svh
// pse_map.svh: offsets, fields and timing counts of the sequencing engine
// assumes inclusion by bare name from the package and the design files
`ifndef PSE_MAP_SVH
`define PSE_MAP_SVH
// register byte offsets, one aligned word each
`define PSE_REG_CTRL      8'h00
`define PSE_REG_STATUS    8'h04
`define PSE_REG_FAULT_A   8'h08
`define PSE_REG_FAULT_B   8'h0C
`define PSE_REG_PROG_ADDR 8'h10
`define PSE_REG_PROG_DATA 8'h14
`define PSE_REG_SRC_SEL   8'h18
`define PSE_REG_HOST_OUT  8'h1C
// control and status fields
`define PSE_CTRL_JUMP     0
`define PSE_CTRL_RUN      1
`define PSE_ST_IDX        5:0
`define PSE_ST_BUSY       8
`define PSE_ST_JUMP       9
`define PSE_ST_DRV        23:16
// state definition, word 0
`define PSE_W0_OUT        7:0
`define PSE_W0_LATCH      8
`define PSE_W0_SEQ_SEL    12:9
`define PSE_W0_SEQ_POL    13
`define PSE_W0_DLY_EN     14
`define PSE_W0_TO_EN      15
`define PSE_W0_SEQ_NEXT   21:16
`define PSE_W0_MON_NEXT   27:22
// state definition, word 1
`define PSE_W1_MASK       12:0
`define PSE_W1_EXPECT     25:13
`define PSE_W1_TO_NEXT    31:26
// state definition, word 2, delays in ticks
`define PSE_W2_SEQ_DLY    15:0
`define PSE_W2_TO_DLY     31:16
// sizes
`define PSE_NUM_STATES    63
`define PSE_MEM_DEPTH     256
`define PSE_IN_W          13
`define PSE_RAW_W         20
// timing
`define PSE_CLK_NS        4
`define PSE_TICK_NS       10000
`define PSE_TICK_CYC      (`PSE_TICK_NS / `PSE_CLK_NS)
`define PSE_OSC_HALF_NS   5000
`define PSE_OSC_HALF_CYC  (`PSE_OSC_HALF_NS / `PSE_CLK_NS)
`endif

// file: verilog/pse_pkg.sv
// pse_pkg: types of the power sequencing engine
// assumes pse_map.svh on the include path
`include "pse_map.svh"
package pse_pkg;
	typedef enum logic [2:0] {
		PH_IDLE, PH_FETCH0, PH_FETCH1, PH_FETCH2, PH_APPLY, PH_RUN
	} pse_phase_e;

	typedef enum logic [1:0] {
		SRC_ENGINE, SRC_HOST, SRC_OSC, SRC_SPARE
	} pse_src_e;

	typedef struct packed {
		logic [`PSE_RAW_W-1:0] sync1;
		logic [`PSE_RAW_W-1:0] sync2;
		pse_phase_e            phase;
		logic [5:0]            state_idx;
		logic [31:0]           def0;
		logic [31:0]           def1;
		logic [31:0]           def2;
		logic [7:0]            out_lvl;
		logic [7:0]            drv_out;
		logic                  run;
		logic                  jump_pend;
		logic                  seq_met;
		logic [15:0]           seq_cnt;
		logic [15:0]           to_cnt;
		logic [11:0]           tick_cnt;
		logic [10:0]           osc_cnt;
		logic                  osc;
		logic [7:0]            fault_a;
		logic [4:0]            fault_b;
		logic [7:0]            prog_addr;
		logic [15:0]           src_sel;
		logic [7:0]            host_out;
		logic                  ack;
		logic [31:0]           rdata;
	} pse_state_s;
endpackage

// file: verilog/pse_def_mem.sv
// pse_def_mem: storage of the state definitions, three words per state
// assumes one clock; read data come out one cycle after the address
`timescale 1ns/1ns
`include "pse_map.svh"
module pse_def_mem (
	input  wire logic        clock,
	input  wire logic        wr_en,
	input  wire logic [7:0]  wr_addr,
	input  wire logic [31:0] wr_data,
	input  wire logic [7:0]  rd_addr,
	output logic      [31:0] rd_data
);
	logic [31:0] mem [0:`PSE_MEM_DEPTH-1];
	logic [31:0] rd_data_ff;

	// contents are not reset; software loads them before setting run
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_ff <= mem[rd_addr];
	end

	assign rd_data = rd_data_ff;
endmodule

// file: verilog/pse_engine.sv
// pse_engine: supply sequencing engine with Avalon-MM register slave
// assumes asynchronous detector and pin inputs; one 250 MHz clock
// Notes on behaviour
// - sixty-three stored state definitions; active index picks the one used
// - every state watches the eight supply detector outputs
// - any next-state field may name any state cell
// - each state has sequence, fault and timeout exits with own targets
// - sequence and timeout timers per state, reloaded on each change
// - driver levels come from the active state and stay fixed in it
// - a state change including definition fetch ends well under 20 us
// - adc and secondary warnings ORed into one input for all exits
// - host jump command forces the sequence exit unless a fault exit is taken first
// - sequence exit waits for the selected input to match its level
// - optional programmed delay before the sequence exit is taken
// - fault exit when any enabled input differs from expected level
// - fault exit has no delay beyond the definition fetch
// - timeout exit when the sequence condition misses its deadline
// - sticky fault bit per input, over two registers
// - host reads the latched fault bits over the bus
// - fault recording enabled or disabled by the active state
// - each driver picks engine level, host value or 100 kHz clock
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "pse_map.svh"
module pse_engine (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [7:0]  supply_fault_detector_ok,
	input  wire logic [3:0]  dual_function_in,
	input  wire logic [3:0]  adc_limit_warn,
	input  wire logic [3:0]  secondary_warn,
	output logic      [7:0]  prog_output_driver
);
	pse_pkg::pse_state_s st_ff;
	pse_pkg::pse_state_s nxt_st;

	logic [31:0]          rd_data;
	logic [7:0]           rd_addr;
	logic                 mem_we;
	logic [`PSE_IN_W-1:0] inp;
	logic [`PSE_IN_W-1:0] mismatch;
	logic                 running;
	logic                 seq_hit;
	logic                 seq_ok;
	logic                 seq_exit;
	logic                 mon_exit;
	logic                 to_exit;
	logic                 take_exit;
	logic [5:0]           mon_dest;
	logic [5:0]           seq_dest;
	logic [5:0]           to_dest;
	logic [5:0]           dest;
	logic                 tick;
	logic                 req;
	logic                 wr_hit;
	logic [7:0]           waddr;
	logic                 clr_fault;
	logic [7:0]           def_out;

	function automatic logic [31:0] be_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction

	// out-of-range targets re-enter the current state
	function automatic logic [5:0] clamp_dest(
		input logic [5:0] raw,
		input logic [5:0] cur
	);
		return (raw < 6'(`PSE_NUM_STATES)) ? raw : cur;
	endfunction

	function automatic logic sel_bit(
		input logic [`PSE_IN_W-1:0] v,
		input logic [3:0]           sel
	);
		return (sel < 4'(`PSE_IN_W)) ? v[sel] : 1'b0;
	endfunction

	pse_def_mem u_def_mem (
		.clock   (clock),
		.wr_en   (mem_we),
		.wr_addr (st_ff.prog_addr),
		.wr_data (avs_writedata),
		.rd_addr (rd_addr),
		.rd_data (rd_data)
	);

	// detector outputs, digital pins, then the ORed warning on top
	assign inp = {|st_ff.sync2[19:12], st_ff.sync2[11:0]};
	assign running = (st_ff.phase == pse_pkg::PH_RUN) && st_ff.run;
	// an index past the inputs never matches, whatever the level asked
	assign seq_hit = st_ff.def0[`PSE_W0_SEQ_SEL] < 4'(`PSE_IN_W)
		&& sel_bit(inp, st_ff.def0[`PSE_W0_SEQ_SEL])
		== st_ff.def0[`PSE_W0_SEQ_POL];
	assign seq_ok = st_ff.seq_met | seq_hit;
	assign seq_exit = (seq_ok && (!st_ff.def0[`PSE_W0_DLY_EN]
		|| st_ff.seq_cnt >= st_ff.def2[`PSE_W2_SEQ_DLY]))
		|| st_ff.jump_pend;
	assign mismatch = (inp ^ st_ff.def1[`PSE_W1_EXPECT])
		& st_ff.def1[`PSE_W1_MASK];
	assign mon_exit = |mismatch;
	assign to_exit = st_ff.def0[`PSE_W0_TO_EN] && !seq_ok
		&& st_ff.to_cnt >= st_ff.def2[`PSE_W2_TO_DLY];
	assign mon_dest = clamp_dest(st_ff.def0[`PSE_W0_MON_NEXT], st_ff.state_idx);
	assign seq_dest = clamp_dest(st_ff.def0[`PSE_W0_SEQ_NEXT], st_ff.state_idx);
	assign to_dest = clamp_dest(st_ff.def1[`PSE_W1_TO_NEXT], st_ff.state_idx);
	assign take_exit = running && (mon_exit || seq_exit || to_exit);
	assign dest = mon_exit ? mon_dest
		: (seq_exit ? seq_dest : to_dest);
	assign tick = st_ff.tick_cnt == 12'(`PSE_TICK_CYC - 1);
	assign def_out = st_ff.def0[`PSE_W0_OUT];

	always_comb begin
		case (st_ff.phase)
			pse_pkg::PH_FETCH1: rd_addr = {st_ff.state_idx, 2'h1};
			pse_pkg::PH_FETCH2: rd_addr = {st_ff.state_idx, 2'h2};
			default:            rd_addr = {st_ff.state_idx, 2'h0};
		endcase
	end

	assign req = avs_read | avs_write;
	assign wr_hit = st_ff.ack && avs_write;
	assign waddr = {avs_address[7:2], 2'h0};
	assign clr_fault = wr_hit && (waddr == `PSE_REG_FAULT_A
		|| waddr == `PSE_REG_FAULT_B);
	assign mem_we = wr_hit && waddr == `PSE_REG_PROG_DATA
		&& avs_byteenable == 4'hF
		&& st_ff.prog_addr[7:2] < 6'(`PSE_NUM_STATES);

	always_comb begin
		logic [31:0] tmp;
		tmp = 32'h0;
		nxt_st = st_ff;
		nxt_st.sync1 = {secondary_warn, adc_limit_warn, dual_function_in,
			supply_fault_detector_ok};
		nxt_st.sync2 = st_ff.sync1;

		// free-running 100 kHz square wave
		if (st_ff.osc_cnt == 11'(`PSE_OSC_HALF_CYC - 1)) begin
			nxt_st.osc_cnt = 11'h000;
			nxt_st.osc = ~st_ff.osc;
		end else begin
			nxt_st.osc_cnt = st_ff.osc_cnt + 11'h001;
		end

		// five cycles from exit to running in the new state
		case (st_ff.phase)
			pse_pkg::PH_IDLE: begin
				if (st_ff.run) begin
					nxt_st.phase = pse_pkg::PH_FETCH0;
				end
			end
			pse_pkg::PH_FETCH0: begin
				nxt_st.phase = pse_pkg::PH_FETCH1;
			end
			pse_pkg::PH_FETCH1: begin
				nxt_st.def0 = rd_data;
				nxt_st.phase = pse_pkg::PH_FETCH2;
			end
			pse_pkg::PH_FETCH2: begin
				nxt_st.def1 = rd_data;
				nxt_st.phase = pse_pkg::PH_APPLY;
			end
			pse_pkg::PH_APPLY: begin
				nxt_st.def2 = rd_data;
				nxt_st.out_lvl = def_out;
				nxt_st.seq_met = 1'b0;
				nxt_st.seq_cnt = 16'h0000;
				nxt_st.to_cnt = 16'h0000;
				nxt_st.tick_cnt = 12'h000;
				nxt_st.phase = pse_pkg::PH_RUN;
			end
			pse_pkg::PH_RUN: begin
				// granularity of both timers is one 10 us tick
				nxt_st.tick_cnt = tick ? 12'h000 : st_ff.tick_cnt + 12'h001;
				nxt_st.seq_met = seq_ok;
				if (tick && st_ff.seq_met && st_ff.seq_cnt != 16'hFFFF) begin
					nxt_st.seq_cnt = st_ff.seq_cnt + 16'h0001;
				end
				if (tick && st_ff.to_cnt != 16'hFFFF) begin
					nxt_st.to_cnt = st_ff.to_cnt + 16'h0001;
				end
				if (!st_ff.run) begin
					nxt_st.phase = pse_pkg::PH_IDLE;
					nxt_st.state_idx = 6'h00;
				end else if (take_exit) begin
					nxt_st.state_idx = dest;
					nxt_st.phase = pse_pkg::PH_FETCH0;
					nxt_st.jump_pend = 1'b0;
				end
			end
			default: begin
				nxt_st.phase = pse_pkg::PH_IDLE;
			end
		endcase

		// driver source select, registered so outputs never glitch
		for (int i = 0; i < 8; i++) begin
			case (pse_pkg::pse_src_e'(st_ff.src_sel[2*i +: 2]))
				pse_pkg::SRC_HOST: nxt_st.drv_out[i] = st_ff.host_out[i];
				pse_pkg::SRC_OSC:  nxt_st.drv_out[i] = st_ff.osc;
				default:           nxt_st.drv_out[i] = st_ff.out_lvl[i];
			endcase
		end

		// bus: one wait cycle, answer on the second
		nxt_st.ack = req && !st_ff.ack;
		if (req && !st_ff.ack && avs_read) begin
			case (waddr)
				`PSE_REG_CTRL: begin
					tmp[`PSE_CTRL_RUN] = st_ff.run;
					tmp[`PSE_CTRL_JUMP] = st_ff.jump_pend;
				end
				`PSE_REG_STATUS: begin
					tmp[`PSE_ST_IDX] = st_ff.state_idx;
					tmp[`PSE_ST_BUSY] = st_ff.phase != pse_pkg::PH_RUN
						&& st_ff.phase != pse_pkg::PH_IDLE;
					tmp[`PSE_ST_JUMP] = st_ff.jump_pend;
					tmp[`PSE_ST_DRV] = st_ff.drv_out;
				end
				`PSE_REG_FAULT_A:   tmp = {24'h0, st_ff.fault_a};
				`PSE_REG_FAULT_B:   tmp = {27'h0, st_ff.fault_b};
				`PSE_REG_PROG_ADDR: tmp = {24'h0, st_ff.prog_addr};
				`PSE_REG_SRC_SEL:   tmp = {16'h0, st_ff.src_sel};
				`PSE_REG_HOST_OUT:  tmp = {24'h0, st_ff.host_out};
				default:            tmp = 32'h0;
			endcase
			nxt_st.rdata = tmp;
		end
		if (wr_hit) begin
			case (waddr)
				`PSE_REG_CTRL: begin
					if (avs_byteenable[0]) begin
						nxt_st.run = avs_writedata[`PSE_CTRL_RUN];
						// a new command beats the clear of a taken one
						if (avs_writedata[`PSE_CTRL_JUMP]) begin
							nxt_st.jump_pend = 1'b1;
						end
					end
				end
				`PSE_REG_FAULT_A: begin
					if (avs_byteenable[0]) begin
						nxt_st.fault_a = st_ff.fault_a & ~avs_writedata[7:0];
					end
				end
				`PSE_REG_FAULT_B: begin
					if (avs_byteenable[0]) begin
						nxt_st.fault_b = st_ff.fault_b & ~avs_writedata[4:0];
					end
				end
				`PSE_REG_PROG_ADDR: begin
					tmp = be_merge({24'h0, st_ff.prog_addr}, avs_writedata,
						avs_byteenable);
					nxt_st.prog_addr = tmp[7:0];
				end
				`PSE_REG_PROG_DATA: begin
					if (mem_we) begin
						nxt_st.prog_addr = st_ff.prog_addr + 8'h01;
					end
				end
				`PSE_REG_SRC_SEL: begin
					tmp = be_merge({16'h0, st_ff.src_sel}, avs_writedata,
						avs_byteenable);
					nxt_st.src_sel = tmp[15:0];
				end
				`PSE_REG_HOST_OUT: begin
					tmp = be_merge({24'h0, st_ff.host_out}, avs_writedata,
						avs_byteenable);
					nxt_st.host_out = tmp[7:0];
				end
				default: begin
					nxt_st.run = st_ff.run;
				end
			endcase
		end

		// set after clear: a fault in the clearing cycle survives
		if (running && st_ff.def0[`PSE_W0_LATCH]) begin
			nxt_st.fault_a = nxt_st.fault_a | mismatch[7:0];
			nxt_st.fault_b = nxt_st.fault_b | mismatch[12:8];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign avs_readdata = st_ff.rdata;
	assign avs_waitrequest = req && !st_ff.ack;
	assign prog_output_driver = st_ff.drv_out;

	sequence s_fetch_rest;
		st_ff.phase == pse_pkg::PH_FETCH1 ##1 st_ff.phase == pse_pkg::PH_FETCH2
		##1 st_ff.phase == pse_pkg::PH_APPLY ##1 st_ff.phase == pse_pkg::PH_RUN;
	endsequence

	property p_load_time;
		@(posedge clock) disable iff (rst)
		st_ff.phase == pse_pkg::PH_FETCH0 |=> s_fetch_rest;
	endproperty
	a_load_time: assert property (p_load_time)
		else $error("state fetch did not finish in four cycles");

	property p_out_apply;
		@(posedge clock) disable iff (rst)
		st_ff.phase == pse_pkg::PH_APPLY |=> st_ff.out_lvl == $past(def_out);
	endproperty
	a_out_apply: assert property (p_out_apply)
		else $error("driver levels not taken from new definition");

	property p_out_hold;
		@(posedge clock) disable iff (rst)
		(st_ff.phase == pse_pkg::PH_RUN)[*2] |-> $stable(st_ff.out_lvl);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("driver levels changed inside a state");

	property p_mon_first;
		@(posedge clock) disable iff (rst)
		running && mon_exit |=> st_ff.phase == pse_pkg::PH_FETCH0
			&& st_ff.state_idx == $past(mon_dest);
	endproperty
	a_mon_first: assert property (p_mon_first)
		else $error("fault exit not taken first");

	property p_seq_exit;
		@(posedge clock) disable iff (rst)
		running && !mon_exit && seq_exit |=> st_ff.state_idx == $past(seq_dest);
	endproperty
	a_seq_exit: assert property (p_seq_exit)
		else $error("sequence exit went to wrong state");

	property p_to_exit;
		@(posedge clock) disable iff (rst)
		running && !mon_exit && !seq_exit && to_exit
			|=> st_ff.state_idx == $past(to_dest);
	endproperty
	a_to_exit: assert property (p_to_exit)
		else $error("timeout exit went to wrong state");

	property p_jump;
		@(posedge clock) disable iff (rst)
		running && st_ff.jump_pend |=> st_ff.phase == pse_pkg::PH_FETCH0;
	endproperty
	a_jump: assert property (p_jump)
		else $error("jump command did not force a state change");

	property p_reload;
		@(posedge clock) disable iff (rst)
		st_ff.phase == pse_pkg::PH_APPLY
			|=> st_ff.seq_cnt == 16'h0000 && st_ff.to_cnt == 16'h0000;
	endproperty
	a_reload: assert property (p_reload)
		else $error("timers not reloaded on state change");

	property p_sticky;
		@(posedge clock) disable iff (rst)
		!clr_fault |=> (st_ff.fault_a & $past(st_ff.fault_a))
			== $past(st_ff.fault_a);
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("fault bit lost without a clear");

	property p_gate;
		@(posedge clock) disable iff (rst)
		!(running && st_ff.def0[`PSE_W0_LATCH]) && !clr_fault
			|=> $stable(st_ff.fault_a) && $stable(st_ff.fault_b);
	endproperty
	a_gate: assert property (p_gate)
		else $error("fault latched while recording disabled");

	property p_fault_read;
		@(posedge clock) disable iff (rst)
		avs_read && !st_ff.ack && waddr == `PSE_REG_FAULT_A
			|=> !avs_waitrequest && avs_readdata[7:0] == $past(st_ff.fault_a);
	endproperty
	a_fault_read: assert property (p_fault_read)
		else $error("fault register read back wrong");
endmodule

// file: sim/pse_supply_model.sv
// pse_supply_model: eight supervised rails behind the detector inputs
// assumes each rail is switched on by the matching engine driver bit
`timescale 1ns/1ns
module pse_supply_model #(
	parameter int RAMP = 20
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [7:0] enable,
	input  wire logic [7:0] fail,
	output logic      [7:0] ok
);
	logic [7:0] cnt_ff [8];

	// a rail reads good only after its ramp; shut off drops at once
	always_ff @(posedge clock) begin
		for (int i = 0; i < 8; i++) begin
			if (rst || !enable[i])
				cnt_ff[i] <= 8'h00;
			else if (cnt_ff[i] != 8'(RAMP))
				cnt_ff[i] <= cnt_ff[i] + 8'h01;
		end
	end

	// forced failure stands for a short on the rail
	always_comb begin
		for (int i = 0; i < 8; i++)
			ok[i] = (cnt_ff[i] == 8'(RAMP)) && !fail[i];
	end
endmodule

// file: sim/pse_engine_bench.sv
// pse_engine_bench: register-level test of the sequencing engine
// assumes pse_map.svh on the include path and the rail model beside it
`timescale 1ns/1ns
`include "pse_map.svh"
module pse_engine_bench;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  rail_ok;
	logic [3:0]  dfi = 4'h0;
	logic [3:0]  adc_warn = 4'h0;
	logic [3:0]  sec_warn = 4'h0;
	logic [7:0]  fail = 8'h00;
	logic [7:0]  drv;
	logic [31:0] q;
	logic        p6;
	int          err_count = 0;
	int          n_compared = 0;
	int          n;

	always #2 clock = ~clock;

	pse_engine u_dut (
		.clock(clock), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.supply_fault_detector_ok(rail_ok), .dual_function_in(dfi),
		.adc_limit_warn(adc_warn), .secondary_warn(sec_warn),
		.prog_output_driver(drv)
	);

	pse_supply_model #(.RAMP(20)) u_rails (
		.clock(clock), .rst(rst), .enable(drv), .fail(fail), .ok(rail_ok)
	);

	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// pin compare at the falling edge, clear of register updates
	task automatic pchk(input string nm, input logic [7:0] e);
		@(negedge clock);
		chk(nm, {24'h0, e}, {24'h0, drv});
	endtask

	// one access; request held until waitrequest is sampled low at an edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= ~w;
		do begin
			@(posedge clock);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		if (avs_waitrequest !== 1'b0) begin
			err_count++;
			$display("mismatch waitrequest expected 0 seen 1");
			end_of_test();
		end
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask

	task automatic prog(input logic [5:0] s, input logic [31:0] w0,
		input logic [31:0] w1, input logic [31:0] w2);
		wr(`PSE_REG_PROG_ADDR, {24'h0, s, 2'b00});
		wr(`PSE_REG_PROG_DATA, w0);
		wr(`PSE_REG_PROG_DATA, w1);
		wr(`PSE_REG_PROG_DATA, w2);
	endtask

	// polls the state index; running out of polls ends the run
	task automatic wait_st(input logic [5:0] s, input int lim);
		int k;
		k = 0;
		bus(1'b0, `PSE_REG_STATUS, 32'h0);
		while (q[5:0] !== s && k < lim) begin
			k++;
			bus(1'b0, `PSE_REG_STATUS, 32'h0);
		end
		chk("state", {26'h0, s}, {26'h0, q[5:0]});
		if (k >= lim)
			end_of_test();
	endtask

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		wr(`PSE_REG_STATUS, 32'hFFFF_FFFF);
		wr(8'h20, 32'hFFFF_FFFF);
		for (int i = 0; i < 9; i++)
			rd(8'(i * 4), 32'h0, "reset value");
		pchk("drivers reset", 8'h00);
		$display("test reset done");
		// 0 idle, 1 rail on, 2 all good, 3 fault, 4 timed out, 62 warned
		prog(6'h00, 32'h0001_3000, 32'h0, 32'h0);
		prog(6'h01, 32'h0002_E001, 32'h1000_0000, 32'h0003_0002);
		prog(6'h02, 32'h00FE_3903, 32'h0000_2001, 32'h0);
		prog(6'h03, 32'h0001_1E80, 32'h0, 32'h0);
		prog(6'h04, 32'h003E_3840, 32'h0, 32'h0);
		prog(6'h3E, 32'h0000_1E3F, 32'h0, 32'h0);
		wr(`PSE_REG_CTRL, 32'h2);
		repeat (20) @(posedge clock);
		rd(`PSE_REG_STATUS, 32'h0, "idle status");
		dfi[0] <= 1'b1;
		wait_st(6'h01, 40);
		repeat (10) @(posedge clock);
		pchk("drivers rail on", 8'h01);
		repeat (1000) @(posedge clock);
		rd(`PSE_REG_STATUS, 32'h0001_0001, "delay hold");
		wait_st(6'h02, 3000);
		repeat (10) @(posedge clock);
		pchk("drivers all good", 8'h03);
		$display("test sequence done");
		@(posedge clock);
		adc_warn[1] <= 1'b1;
		fail[0]     <= 1'b1;
		wait_st(6'h03, 20);
		adc_warn[1] <= 1'b0;
		rd(`PSE_REG_FAULT_A, 32'h1, "fault a");
		rd(`PSE_REG_FAULT_B, 32'h0, "fault b");
		wr(`PSE_REG_FAULT_A, 32'h1);
		rd(`PSE_REG_FAULT_A, 32'h0, "fault a clear");
		$display("test fault done");
		wr(`PSE_REG_CTRL, 32'h3);
		wait_st(6'h01, 20);
		rd(`PSE_REG_CTRL, 32'h2, "jump cleared");
		repeat (4000) @(posedge clock);
		rd(`PSE_REG_STATUS, 32'h0001_0001, "timeout hold");
		wait_st(6'h04, 3000);
		$display("test timeout done");
		sec_warn[3] <= 1'b1;
		wait_st(6'h3E, 20);
		// byte lane 1 only: low byte of the write must be dropped
		avs_byteenable <= 4'h2;
		wr(`PSE_REG_SRC_SEL, 32'h0000_60FF);
		avs_byteenable <= 4'hF;
		rd(`PSE_REG_SRC_SEL, 32'h0000_6000, "source select");
		wr(`PSE_REG_HOST_OUT, 32'h80);
		repeat (4) @(posedge clock);
		@(negedge clock);
		chk("driver lanes", 32'hBF, {24'h0, drv & 8'hBF});
		for (int j = 0; j < 2; j++) begin
			n = 0;
			p6 = drv[6];
			while (drv[6] === p6 && n < 1300) begin
				@(negedge clock);
				n++;
			end
		end
		chk("clock half period", 32'h0000_04E2, 32'(n));
		$display("test source select done");
		end_of_test();
	end
endmodule
